// ### wpm_interface_unit.sv
// Interface unit: maps peripheral windows onto memory or interconnect
`timescale 1ns/100ps
module wpm_interface_unit (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	// Peripheral bus
	wpm_ps_if.unit                             ps,
	// Central system access
	output logic                               sysReq,
	output logic                               sysWe,
	output logic                               sysIc,
	output logic                               sysPhys,
	output logic [wpm_pkg::DISP_W-1:0]         sysSel,
	output logic [wpm_pkg::BASE_W-1:0]         sysAddr,
	output logic [wpm_pkg::DATA_W-1:0]         sysWdata,
	input  wire logic [wpm_pkg::DATA_W-1:0]    sysRdata,
	input  wire logic                          sysAck,
	input  wire logic                          sysFault,
	// Status
	output logic                               funcDone,
	output logic                               physMode,
	output logic                               w1Interconnect
);

	typedef enum logic [1:0] {
		U_IDLE = 2'h0,
		U_SYS  = 2'h1,
		U_DONE = 2'h2
	} wpm_ustate_t;

	function automatic logic [wpm_pkg::BASE_W-1:0] winAddr(
		input logic [wpm_pkg::BASE_W-1:0] base,
		input logic [wpm_pkg::DISP_W-1:0] disp);
		winAddr = base + {{(wpm_pkg::BASE_W-wpm_pkg::DISP_W){1'b0}}, disp};
	endfunction : winAddr

	////////////////////////////////////////////////////////////////////////
	// State
	wpm_ustate_t                      stateReg;
	logic                             modePhysReg;
	logic                             w1IcReg;
	logic                             errReg;
	logic [wpm_pkg::BASE_W-1:0]       baseReg [wpm_pkg::NUM_WIN];
	logic [wpm_pkg::DISP_W-1:0]       selReg  [wpm_pkg::NUM_WIN];
	logic [wpm_pkg::DISP_W-1:0]       opLoReg;
	logic [wpm_pkg::DISP_W-1:0]       opHiReg;
	logic                             sysReqReg;
	logic                             sysWeReg;
	logic                             sysIcReg;
	logic                             sysPhysReg;
	logic [wpm_pkg::DISP_W-1:0]       sysSelReg;
	logic [wpm_pkg::BASE_W-1:0]       sysAddrReg;
	logic [wpm_pkg::DATA_W-1:0]       sysWdataReg;
	logic [wpm_pkg::DATA_W-1:0]       rdataReg;
	logic                             ackReg;
	logic                             psErrReg;
	logic                             funcDoneReg;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire logic [wpm_pkg::REGION_W-1:0] region = ps.psAddr[wpm_pkg::ADDR_W-1:wpm_pkg::DISP_W];
	wire logic [wpm_pkg::DISP_W-1:0]   disp   = ps.psAddr[wpm_pkg::DISP_W-1:0];
	wire logic [1:0]                   winIdx = region[1:0];
	wire logic       take     = (stateReg == U_IDLE) && ps.psReq;
	wire logic       isWin    = (region < 3'(wpm_pkg::NUM_WIN));
	wire logic       isCtl    = (region == wpm_pkg::REGION_CTRL);
	wire logic       isIc     = (region == wpm_pkg::REGION_IC_WIN) && w1IcReg;
	wire logic       misalign = isIc && disp[0];
	wire logic       winGo    = take && isWin && !misalign;
	wire logic       ctlWr    = take && isCtl && ps.psWe;
	wire logic       opExec   = ctlWr && (disp == wpm_pkg::CW_OPCODE);
	wire logic       badAcc   = take && !isCtl && (!isWin || misalign);

	// Physical mode: base plus displacement; logical: offset in selected object
	wire logic [wpm_pkg::BASE_W-1:0] physAddr = winAddr(baseReg[winIdx], disp);
	wire logic [wpm_pkg::BASE_W-1:0] logAddr  =
		{{(wpm_pkg::BASE_W-wpm_pkg::DISP_W){1'b0}}, disp};
	wire logic [wpm_pkg::BASE_W-1:0] tgtAddr  = modePhysReg ? physAddr : logAddr;

	// Function decode
	wire logic [3:0] fnCode = ps.psWdata[wpm_pkg::OPC_FN_LSB +: 4];
	wire logic [1:0] fnWin  = ps.psWdata[wpm_pkg::OPC_WIN_LSB +: 2];
	wire logic fnMap   = (fnCode == wpm_pkg::FN_ALTER_MAP);
	wire logic fnPhys  = (fnCode == wpm_pkg::FN_SET_PHYS);
	wire logic fnLogic = (fnCode == wpm_pkg::FN_SET_LOGIC);
	wire logic fnSw    = (fnCode == wpm_pkg::FN_SWITCH_W1);
	wire logic fnSel   = (fnCode == wpm_pkg::FN_SET_SEL);
	wire logic fnKnown = fnMap || fnPhys || fnLogic || fnSw || fnSel;
	wire logic fnReject = !fnKnown || (modePhysReg && fnSel);
	wire logic fnOk    = opExec && !fnReject;
	wire logic [wpm_pkg::BASE_W-1:0] opBase = {opHiReg[7:0], opLoReg};

	// Answer fault: protection faults count only in logical mode
	wire logic sysErr = sysFault && !modePhysReg;

	wire logic [wpm_pkg::DATA_W-1:0] statusWord =
		(wpm_pkg::DATA_W'(errReg) << wpm_pkg::ST_ERR_BIT) |
		(wpm_pkg::DATA_W'(modePhysReg) << wpm_pkg::ST_PHYS_BIT) |
		(wpm_pkg::DATA_W'(w1IcReg) << wpm_pkg::ST_IC_BIT);
	wire logic [wpm_pkg::DATA_W-1:0] ctlRd =
		(disp == wpm_pkg::CW_STATUS)     ? statusWord :
		(disp == wpm_pkg::CW_OPERAND_LO) ? opLoReg :
		(disp == wpm_pkg::CW_OPERAND_HI) ? opHiReg : 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Transfer sequencing
	wpm_ustate_t stateNext;
	always_comb begin
		stateNext = stateReg;
		case (stateReg)
			U_IDLE: begin
				if (winGo) begin
					stateNext = U_SYS;
				end else if (take) begin
					stateNext = U_DONE;
				end
			end
			U_SYS: begin
				if (sysAck) begin
					stateNext = U_DONE;
				end
			end
			U_DONE: stateNext = U_IDLE;
			default: stateNext = U_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stateReg <= U_IDLE;
		end else begin
			stateReg <= stateNext;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// System side request
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sysReqReg   <= 1'b0;
			sysWeReg    <= 1'b0;
			sysIcReg    <= 1'b0;
			sysPhysReg  <= 1'b0;
			sysSelReg   <= wpm_pkg::SEL_RESET;
			sysAddrReg  <= wpm_pkg::BASE_RESET;
			sysWdataReg <= 16'h0000;
		end else if (winGo) begin
			sysReqReg   <= 1'b1;
			sysWeReg    <= ps.psWe;
			sysIcReg    <= isIc;
			sysPhysReg  <= modePhysReg;
			sysSelReg   <= selReg[winIdx];
			sysAddrReg  <= tgtAddr;
			sysWdataReg <= ps.psWdata;
		end else if ((stateReg == U_SYS) && sysAck) begin
			sysReqReg   <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Peripheral answer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ackReg   <= 1'b0;
			psErrReg <= 1'b0;
			rdataReg <= 16'h0000;
		end else if ((stateReg == U_SYS) && sysAck) begin
			ackReg   <= 1'b1;
			psErrReg <= sysErr;
			rdataReg <= sysWeReg ? 16'h0000 : sysRdata;
		end else if (take && !winGo) begin
			ackReg   <= 1'b1;
			psErrReg <= badAcc || (opExec && fnReject);
			rdataReg <= (isCtl && !ps.psWe) ? ctlRd : 16'h0000;
		end else begin
			ackReg   <= 1'b0;
			psErrReg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Function request facility
	always_ff @(posedge core_clk) begin
		if (rst) begin
			opLoReg <= 16'h0000;
			opHiReg <= 16'h0000;
		end else if (ctlWr && (disp == wpm_pkg::CW_OPERAND_LO)) begin
			opLoReg <= ps.psWdata;
		end else if (ctlWr && (disp == wpm_pkg::CW_OPERAND_HI)) begin
			opHiReg <= ps.psWdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			modePhysReg <= 1'b0;
			w1IcReg     <= 1'b0;
			errReg      <= 1'b0;
			funcDoneReg <= 1'b0;
		end else begin
			funcDoneReg <= opExec;
			if (opExec) begin
				errReg <= fnReject;
			end
			if (fnOk && fnPhys) begin
				modePhysReg <= 1'b1;
			end else if (fnOk && fnLogic) begin
				modePhysReg <= 1'b0;
			end
			if (fnOk && fnSw) begin
				w1IcReg <= opLoReg[0];
			end
		end
	end

	// Window map: base in physical mode, selector in logical mode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < wpm_pkg::NUM_WIN; i++) begin
				baseReg[i] <= wpm_pkg::BASE_RESET;
				selReg[i]  <= wpm_pkg::SEL_RESET;
			end
		end else if (fnOk && fnMap && modePhysReg) begin
			baseReg[fnWin] <= opBase;
		end else if (fnOk && (fnMap || fnSel)) begin
			selReg[fnWin]  <= opLoReg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign ps.psAck       = ackReg;
	assign ps.psErr       = psErrReg;
	assign ps.psRdata     = rdataReg;
	assign sysReq         = sysReqReg;
	assign sysWe          = sysWeReg;
	assign sysIc          = sysIcReg;
	assign sysPhys        = sysPhysReg;
	assign sysSel         = sysSelReg;
	assign sysAddr        = sysAddrReg;
	assign sysWdata       = sysWdataReg;
	assign funcDone       = funcDoneReg;
	assign physMode       = modePhysReg;
	assign w1Interconnect = w1IcReg;

endmodule : wpm_interface_unit

// ### wpm_pkg.sv
// Shared constants and types for the window mapping interconnect block
package wpm_pkg;
	// Peripheral bus address layout
	localparam int DISP_W      = 16;
	localparam int BASE_W      = 24;
	localparam int DATA_W      = 16;
	localparam int REGION_W    = 3;
	localparam int ADDR_W      = REGION_W + DISP_W;
	localparam int NUM_WIN     = 4;
	localparam logic [REGION_W-1:0] REGION_CTRL = 3'h4;
	localparam logic [REGION_W-1:0] REGION_IC_WIN = 3'h1;

	// Control window offsets
	localparam logic [DISP_W-1:0] CW_OPERAND_LO = 16'h0000;
	localparam logic [DISP_W-1:0] CW_OPERAND_HI = 16'h0002;
	localparam logic [DISP_W-1:0] CW_OPCODE     = 16'h0004;
	localparam logic [DISP_W-1:0] CW_STATUS     = 16'h0006;

	// Opcode word fields
	localparam int OPC_FN_LSB  = 0;
	localparam int OPC_WIN_LSB = 4;

	// Status word bits
	localparam int ST_ERR_BIT  = 0;
	localparam int ST_PHYS_BIT = 1;
	localparam int ST_IC_BIT   = 2;

	// Interconnect addresses the system must provide
	localparam logic [BASE_W-1:0] IC_PROC_ID_ADDR = 24'h000000;
	localparam logic [BASE_W-1:0] IC_SIGNAL_ADDR  = 24'h000002;

	// Reset values
	localparam logic [BASE_W-1:0] BASE_RESET = 24'h000000;
	localparam logic [DISP_W-1:0] SEL_RESET  = 16'h0000;

	typedef enum logic [3:0] {
		FN_NONE      = 4'h0,
		FN_ALTER_MAP = 4'h1,
		FN_SET_PHYS  = 4'h2,
		FN_SET_LOGIC = 4'h3,
		FN_SWITCH_W1 = 4'h4,
		FN_SET_SEL   = 4'h5
	} wpm_fn_t;

	typedef enum logic [1:0] {
		CMD_READ  = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_OPEN  = 2'h2,
		CMD_FUNC  = 2'h3
	} wpm_cmd_t;
endpackage : wpm_pkg

// ### wpm_ps_if.sv
// Peripheral subsystem bus between attached host and interface unit
`timescale 1ns/100ps
interface wpm_ps_if;
	logic                               psReq;
	logic                               psWe;
	logic [wpm_pkg::ADDR_W-1:0]         psAddr;
	logic [wpm_pkg::DATA_W-1:0]         psWdata;
	logic [wpm_pkg::DATA_W-1:0]         psRdata;
	logic                               psAck;
	logic                               psErr;

	modport host (
		output psReq,
		output psWe,
		output psAddr,
		output psWdata,
		input  psRdata,
		input  psAck,
		input  psErr
	);

	modport unit (
		input  psReq,
		input  psWe,
		input  psAddr,
		input  psWdata,
		output psRdata,
		output psAck,
		output psErr
	);
endinterface : wpm_ps_if

// ### wpm_attached_host.sv
// Attached host: turns user commands into peripheral bus sequences
`timescale 1ns/100ps
module wpm_attached_host (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	// Peripheral bus
	wpm_ps_if.host                             ps,
	// User command
	input  wire logic                          cmdValid,
	output logic                               cmdReady,
	input  wire logic [1:0]                    cmdOp,
	input  wire logic [wpm_pkg::REGION_W-1:0]  cmdRegion,
	input  wire logic [wpm_pkg::DISP_W-1:0]    cmdDisp,
	input  wire logic [wpm_pkg::BASE_W-1:0]    cmdData,
	input  wire logic [wpm_pkg::DATA_W-1:0]    cmdOpcode,
	// User response
	output logic                               rspValid,
	output logic [wpm_pkg::DATA_W-1:0]         rspData,
	output logic                               rspErr
);

	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_BUS  = 2'h1
	} wpm_hstate_t;

	wpm_hstate_t                     stateReg;
	logic [1:0]                      opReg;
	logic [1:0]                      stepReg;
	logic [wpm_pkg::REGION_W-1:0]    regionReg;
	logic [wpm_pkg::DISP_W-1:0]      dispReg;
	logic [wpm_pkg::BASE_W-1:0]      dataReg;
	logic [wpm_pkg::DATA_W-1:0]      opcReg;
	logic                            reqReg;
	logic                            rspValidReg;
	logic [wpm_pkg::DATA_W-1:0]      rspDataReg;
	logic                            rspErrReg;
	logic                            errAccReg;
	logic                            readyReg;

	////////////////////////////////////////////////////////////////////////
	// Step decode: function = operand lo, operand hi, opcode, status read
	wire logic isFunc  = (opReg == wpm_pkg::CMD_OPEN) || (opReg == wpm_pkg::CMD_FUNC);
	wire logic lastStep = !isFunc || (stepReg == 2'h3);
	wire logic [wpm_pkg::DATA_W-1:0] openOpc =
		16'(wpm_pkg::FN_ALTER_MAP) | (16'(regionReg[1:0]) << wpm_pkg::OPC_WIN_LSB);
	wire logic [wpm_pkg::DISP_W-1:0] stepDisp =
		(stepReg == 2'h0) ? wpm_pkg::CW_OPERAND_LO :
		(stepReg == 2'h1) ? wpm_pkg::CW_OPERAND_HI :
		(stepReg == 2'h2) ? wpm_pkg::CW_OPCODE : wpm_pkg::CW_STATUS;
	// Base (physical) or selector (logical) rides in the operands
	wire logic [wpm_pkg::DATA_W-1:0] stepData =
		(stepReg == 2'h0) ? dataReg[15:0] :
		(stepReg == 2'h1) ? {8'h00, dataReg[23:16]} :
		(opReg == wpm_pkg::CMD_OPEN) ? openOpc : opcReg;
	wire logic [wpm_pkg::ADDR_W-1:0] busAddr = isFunc ?
		{wpm_pkg::REGION_CTRL, stepDisp} : {regionReg, dispReg};
	wire logic busWe = isFunc ? (stepReg != 2'h3) : (opReg == wpm_pkg::CMD_WRITE);
	wire logic [wpm_pkg::DATA_W-1:0] busWdata = isFunc ? stepData : dataReg[15:0];
	wire logic accept = (stateReg == H_IDLE) && cmdValid;
	wire logic done   = (stateReg == H_BUS) && ps.psAck && lastStep;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stateReg  <= H_IDLE;
			opReg     <= wpm_pkg::CMD_READ;
			stepReg   <= 2'h0;
			regionReg <= 3'h0;
			dispReg   <= 16'h0000;
			dataReg   <= wpm_pkg::BASE_RESET;
			opcReg    <= 16'h0000;
			reqReg    <= 1'b0;
			errAccReg <= 1'b0;
			readyReg  <= 1'b1;
		end else begin
			case (stateReg)
				H_IDLE: begin
					if (accept) begin
						stateReg  <= H_BUS;
						opReg     <= cmdOp;
						stepReg   <= 2'h0;
						regionReg <= cmdRegion;
						dispReg   <= cmdDisp;
						dataReg   <= cmdData;
						opcReg    <= cmdOpcode;
						reqReg    <= 1'b1;
						errAccReg <= 1'b0;
						readyReg  <= 1'b0;
					end
				end
				H_BUS: begin
					if (ps.psAck) begin
						reqReg    <= !lastStep;
						stepReg   <= stepReg + 2'h1;
						errAccReg <= errAccReg | ps.psErr;
						if (lastStep) begin
							stateReg <= H_IDLE;
							readyReg <= 1'b1;
						end
					end
				end
				default: begin
					stateReg <= H_IDLE;
					readyReg <= 1'b1;
				end
			endcase
		end
	end

	// Status read ends a function; its error bit joins bus errors
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rspValidReg <= 1'b0;
			rspDataReg  <= 16'h0000;
			rspErrReg   <= 1'b0;
		end else begin
			rspValidReg <= done;
			if (done) begin
				rspDataReg <= ps.psRdata;
				rspErrReg  <= errAccReg | ps.psErr |
					(isFunc && ps.psRdata[wpm_pkg::ST_ERR_BIT]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign ps.psReq   = reqReg;
	assign ps.psWe    = busWe;
	assign ps.psAddr  = busAddr;
	assign ps.psWdata = busWdata;
	assign cmdReady   = readyReg;
	assign rspValid   = rspValidReg;
	assign rspData    = rspDataReg;
	assign rspErr     = rspErrReg;

endmodule : wpm_attached_host

// ### wpm_chk.sv
// Checker on the peripheral bus between attached host and interface unit
`timescale 1ns/100ps
module wpm_chk (
	// Clock and reset
	input wire logic                       core_clk,
	input wire logic                       rst,
	// Peripheral bus
	input wire logic                       psReq,
	input wire logic                       psWe,
	input wire logic [wpm_pkg::ADDR_W-1:0] psAddr,
	input wire logic [wpm_pkg::DATA_W-1:0] psWdata,
	input wire logic [wpm_pkg::DATA_W-1:0] psRdata,
	input wire logic                       psAck,
	input wire logic                       psErr
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	wire [2:0] region = psAddr[wpm_pkg::ADDR_W-1:wpm_pkg::DISP_W];
	////////////////////////////////////////////////////////////////
	property p_unmapped;
		$rose(psReq) && region > wpm_pkg::REGION_CTRL |=> psAck && psErr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused");
	property p_ctrl;
		$rose(psReq) && region == wpm_pkg::REGION_CTRL |=> psAck;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("Control access not answered");
	property p_win;
		$rose(psReq) && region < wpm_pkg::REGION_CTRL && region != wpm_pkg::REGION_IC_WIN
			|=> !psAck ##[1:20] psAck;
	endproperty
	a_win: assert property (p_win) else $error("Window access timing wrong");
	property p_w1;
		$rose(psReq) && region == wpm_pkg::REGION_IC_WIN |-> ##[1:20] psAck;
	endproperty
	a_w1: assert property (p_w1) else $error("Window one access not answered");
	property p_err;
		psErr |-> psAck;
	endproperty
	a_err: assert property (p_err) else $error("Error without acknowledge");
	property p_pulse;
		psAck |=> !psAck;
	endproperty
	a_pulse: assert property (p_pulse) else $error("Acknowledge longer than one cycle");
	property p_hold;
		psReq && !psAck |=> psReq && $stable(psAddr) && $stable(psWe);
	endproperty
	a_hold: assert property (p_hold) else $error("Request changed before acknowledge");
	property p_drop;
		psAck && !(psWe && region == wpm_pkg::REGION_CTRL) |=> !psReq;
	endproperty
	a_drop: assert property (p_drop) else $error("Request not dropped after acknowledge");
	property p_rdata;
		psAck |=> $stable(psRdata);
	endproperty
	a_rdata: assert property (p_rdata) else $error("Read data not held");
endmodule : wpm_chk

// ### test_window_physical_interconnect_map.sv
// Testbench joining attached host and interface unit over the peripheral bus
`timescale 1ns/100ps
module test_window_physical_interconnect_map;
	// User side
	logic        core_clk  = 1'h0;
	logic        rst       = 1'h1;
	logic        cmdValid  = 1'h0;
	logic        cmdReady;
	logic [1:0]  cmdOp     = 2'h0;
	logic [2:0]  cmdRegion = 3'h0;
	logic [15:0] cmdDisp   = 16'h0000;
	logic [23:0] cmdData   = 24'h000000;
	logic [15:0] cmdOpcode = 16'h0000;
	logic        rspValid;
	logic [15:0] rspData;
	logic        rspErr;
	// System side
	logic        sysReq;
	logic        sysWe;
	logic        sysIc;
	logic        sysPhys;
	logic [15:0] sysSel;
	logic [23:0] sysAddr;
	logic [15:0] sysWdata;
	logic [15:0] sysRdata;
	logic        sysAck    = 1'h0;
	logic        sysFault  = 1'h0;
	logic        funcDone;
	logic        physMode;
	logic        w1Interconnect;
	// Bench state
	logic [58:0] seenSys   = '0;
	logic [15:0] gotData;
	logic        gotErr;
	int          sysCount  = 0;
	int          sysSlow   = 0;
	int          waitCnt   = 0;
	int          n;
	int          bad_count = 0;
	int          compares  = 0;
	int          fnCount   = 0;
	// Arbitrary identification value
	localparam logic [15:0] PROC_ID_VAL = 16'h3C5E;
	localparam logic [15:0] SIGNAL_VAL  = 16'h0A06;
	////////////////////////////////////////////////////////////////
	wpm_ps_if wpm_ps_if_i ();
	wpm_interface_unit wpm_interface_unit_i (.core_clk(core_clk), .rst(rst), .ps(wpm_ps_if_i),
		.sysReq(sysReq), .sysWe(sysWe), .sysIc(sysIc), .sysPhys(sysPhys), .sysSel(sysSel),
		.sysAddr(sysAddr), .sysWdata(sysWdata), .sysRdata(sysRdata), .sysAck(sysAck),
		.sysFault(sysFault), .funcDone(funcDone), .physMode(physMode),
		.w1Interconnect(w1Interconnect));
	wpm_attached_host wpm_attached_host_i (.core_clk(core_clk), .rst(rst), .ps(wpm_ps_if_i),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdRegion(cmdRegion),
		.cmdDisp(cmdDisp), .cmdData(cmdData), .cmdOpcode(cmdOpcode), .rspValid(rspValid),
		.rspData(rspData), .rspErr(rspErr));
	wpm_chk wpm_chk_i (.core_clk(core_clk), .rst(rst), .psReq(wpm_ps_if_i.psReq),
		.psWe(wpm_ps_if_i.psWe), .psAddr(wpm_ps_if_i.psAddr), .psWdata(wpm_ps_if_i.psWdata),
		.psRdata(wpm_ps_if_i.psRdata), .psAck(wpm_ps_if_i.psAck), .psErr(wpm_ps_if_i.psErr));
	////////////////////////////////////////////////////////////////
	always #4 core_clk = ~core_clk;
	// System answers after sysSlow cycles
	always @(negedge core_clk) begin
		sysAck <= sysReq && !sysAck && (waitCnt >= sysSlow);
		waitCnt <= (sysReq && !sysAck) ? waitCnt + 1 : 0;
	end
	assign sysRdata = !sysAck ? ~sysAddr[15:0] :
		(sysIc && sysAddr == wpm_pkg::IC_PROC_ID_ADDR) ? PROC_ID_VAL :
		(sysIc && sysAddr == wpm_pkg::IC_SIGNAL_ADDR) ? SIGNAL_VAL :
		sysAddr[15:0] ^ 16'h5A5A;
	always @(posedge core_clk) begin
		if (funcDone) fnCount <= fnCount + 1;
		if (sysReq && sysAck) begin
			sysCount <= sysCount + 1;
			seenSys  <= {sysWe, sysIc, sysPhys, sysSel, sysAddr, sysWdata};
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : chk
	task automatic cmd(input logic [1:0] op, input logic [2:0] rg, input logic [15:0] d,
		input logic [23:0] dat, input logic [15:0] opc);
		int k;
		k = 0;
		cmdOp = op;
		cmdRegion = rg;
		cmdDisp = d;
		cmdData = dat;
		cmdOpcode = opc;
		cmdValid = 1'h1;
		@(negedge core_clk);
		cmdValid = 1'h0;
		while (rspValid !== 1'h1 && k < 200) begin
			@(negedge core_clk);
			k++;
		end
		if (k == 200) bad_count++;
		gotData = rspData;
		gotErr = rspErr;
		@(negedge core_clk);
	endtask : cmd
	task automatic rd(input logic [2:0] rg, input logic [15:0] d);
		cmd(wpm_pkg::CMD_READ, rg, d, 24'h000000, 16'h0000);
	endtask : rd
	task automatic wr(input logic [2:0] rg, input logic [15:0] d, input logic [15:0] w);
		cmd(wpm_pkg::CMD_WRITE, rg, d, {8'h00, w}, 16'h0000);
	endtask : wr
	task automatic fn(input logic [3:0] f, input logic [1:0] w, input logic [23:0] d);
		cmd(wpm_pkg::CMD_FUNC, wpm_pkg::REGION_CTRL, 16'h0000, d, {10'h000, w, f});
	endtask : fn
	////////////////////////////////////////////////////////////////
	task automatic t_logical;
		chk(physMode, 1'h0);
		chk(cmdReady, 1'h1);
		chk(w1Interconnect, 1'h0);
		cmd(wpm_pkg::CMD_OPEN, 3'h2, 16'h0000, 24'h000099, 16'h0021);
		rd(3'h2, 16'h0010);
		chk(seenSys[58:16], {3'h0, 16'h0099, 24'h000010});
		chk(gotData, 16'h0010 ^ 16'h5A5A);
		fn(wpm_pkg::FN_SET_SEL, 2'h3, 24'h00BEEF);
		wr(3'h3, 16'hFFFE, 16'hC3C3);
		chk(seenSys, {3'h4, 16'hBEEF, 24'h00FFFE, 16'hC3C3});
		sysFault = 1'h1;
		rd(3'h0, 16'h0000);
		chk(gotErr, 1'h1);
		sysFault = 1'h0;
		fn(4'h0, 2'h0, 24'h000000);
		chk(gotErr, 1'h1);
		fn(4'hF, 2'h0, 24'h000000);
		chk(gotErr, 1'h1);
	endtask : t_logical
	task automatic t_physical;
		fn(wpm_pkg::FN_SET_PHYS, 2'h0, 24'h000000);
		chk(physMode, 1'h1);
		chk(gotData[wpm_pkg::ST_PHYS_BIT], 1'h1);
		fn(wpm_pkg::FN_ALTER_MAP, 2'h0, 24'hABFFF0);
		fn(wpm_pkg::FN_ALTER_MAP, 2'h3, 24'h100000);
		sysSlow = 3;
		rd(3'h0, 16'h0020);
		chk({seenSys[58:56], seenSys[39:16]}, {3'h1, 24'hAC0010});
		wr(3'h3, 16'hFFFE, 16'h1357);
		chk({seenSys[58:56], seenSys[39:0]}, {3'h5, 24'h10FFFE, 16'h1357});
		sysSlow = 0;
		sysFault = 1'h1;
		rd(3'h0, 16'h0000);
		chk(gotErr, 1'h0);
		sysFault = 1'h0;
		fn(wpm_pkg::FN_SET_SEL, 2'h1, 24'h000042);
		chk(gotErr, 1'h1);
		chk(gotData[wpm_pkg::ST_ERR_BIT], 1'h1);
	endtask : t_physical
	task automatic t_interconnect;
		fn(wpm_pkg::FN_SWITCH_W1, 2'h1, 24'h000001);
		chk(w1Interconnect, 1'h1);
		fn(wpm_pkg::FN_ALTER_MAP, 2'h1, 24'h000000);
		rd(3'h1, 16'h0002);
		chk({seenSys[58:56], seenSys[39:16]}, {3'h3, wpm_pkg::IC_SIGNAL_ADDR});
		chk(gotData, SIGNAL_VAL);
		rd(3'h1, 16'h0000);
		chk({seenSys[57], seenSys[39:16]}, {1'h1, wpm_pkg::IC_PROC_ID_ADDR});
		chk(gotData, PROC_ID_VAL);
		n = sysCount;
		rd(3'h1, 16'h0003);
		chk(gotErr, 1'h1);
		chk(sysCount, n);
		rd(3'h0, 16'h0004);
		chk(seenSys[57], 1'h0);
		fn(wpm_pkg::FN_SET_LOGIC, 2'h0, 24'h000000);
		chk(physMode, 1'h0);
		fn(wpm_pkg::FN_ALTER_MAP, 2'h1, 24'h000777);
		rd(3'h1, 16'h0004);
		chk(seenSys[58:16], {3'h2, 16'h0777, 24'h000004});
	endtask : t_interconnect
	task automatic t_unmapped;
		n = sysCount;
		for (int r = 5; r < 8; r++) begin
			rd(r[2:0], 16'h0000);
			chk(gotErr, 1'h1);
		end
		chk(sysCount, n);
		rd(wpm_pkg::REGION_CTRL, wpm_pkg::CW_STATUS);
		chk(gotData[2:0], 3'h4);
		chk(fnCount, 12);
	endtask : t_unmapped
	////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
	initial begin
		repeat (3) @(negedge core_clk);
		rst = 1'h0;
		@(negedge core_clk);
		t_logical();
		t_physical();
		t_interconnect();
		t_unmapped();
		test_done();
	end
endmodule : test_window_physical_interconnect_map
